// *** logic/xpd_decoder.sv ***
// Extension bus address decoder with its enable register and per-target bus timing.
// Assumes a CPU master holding addr/strobes for one cycle and waiting for acc_done.
// Function
// [R1] Flat 16M-byte space, every address reachable by byte or word access.
// [R2] 00E000-00E7FF goes to RAM A when global and RAM A enables set.
// [R3] RAM A window goes external when either enable is clear.
// [R4] 00C000-00DFFF goes to RAM B when global and bit 3 set.
// [R5] RAM B window goes external when either enable is clear.
// [R6] Extension RAM: 16-bit demultiplexed, zero wait states, byte and word.
// [R7] Extension RAM is not bit addressable nor usable as stack or banks.
// [R8] 00EF00-00EFFF goes to CAN A when global and bit 0 set.
// [R9] 00EE00-00EEFF goes to CAN B when global and bit 1 set.
// [R10] CAN accesses: demultiplexed, 16-bit, bytes allowed, two wait states.
// [R11] CAN A enable gates its access and releases its two port pins.
// [R12] CAN A window goes external only if CAN B also disabled.
// [R13] Peripherals disabled before global enable occupy no space, pins, interrupts.
// [R14] With any CAN in use, only four segment address lines drive out.
// [R15] Reset enables CAN A and RAM A, disables CAN B and RAM B.
// [R16] Enable register ignores writes once the global enable is set.
// [R17] Both CAN off: whole 00EE00-00EFFF span goes external.
// [R18] Any address outside enabled windows passes external unchanged.
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
module xpd_decoder
   import xpd_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [15:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   input wire logic [23:0] cpu_addr,
   input wire logic cpu_req,
   input wire logic cpu_write,
   input wire logic cpu_byte,
   input wire logic cpu_bit_op,
   output logic [23:0] tgt_addr,
   output logic tgt_write,
   output logic tgt_byte,
   output logic sel_ext,
   output logic sel_ram_a,
   output logic sel_ram_b,
   output logic sel_can_a,
   output logic sel_can_b,
   output logic acc_done,
   output logic acc_error,
   output logic can_a_pins_claimed,
   output logic can_b_pins_claimed,
   output logic can_a_irq_en,
   output logic can_b_irq_en,
   output logic rtc_en,
   output logic [3:0] seg_lines,
   output logic global_en
);
   ////////////////////////////////////////////////////////////////////////////////
   // Registers.
   logic [4:0] periph_en_reg;
   logic [4:0] periph_en_next;
   logic [15:0] syscfg_reg;
   logic [15:0] syscfg_next;
   logic [15:0] rdata_reg;
   logic [15:0] rdata_next;
   xpd_state_t state_reg;
   xpd_state_t state_next;
   xpd_target_t tgt_reg;
   xpd_target_t tgt_next;

   function automatic logic reg_hit(input logic [15:0] a, input logic [15:0] off);
      reg_hit = (a == off);
   endfunction : reg_hit

   always_comb begin
      periph_en_next = periph_en_reg;
      syscfg_next = syscfg_reg;
      rdata_next = 16'h0000;
      if (reg_wr) begin
         // The freeze looks at the stored global bit, so the selection made before it holds.
         if (reg_hit(reg_addr, XPD_PERIPH_ENABLE_OFFSET) && !syscfg_reg[XPD_GLOBAL_BIT]) begin
            periph_en_next = reg_wdata[4:0] & XPD_PERIPH_ENABLE_MASK; // [R16]
         end
         if (reg_hit(reg_addr, XPD_SYSCFG_OFFSET)) begin
            syscfg_next = reg_wdata;
         end
      end
      if (reg_rd) begin
         case (reg_addr)
            XPD_PERIPH_ENABLE_OFFSET: rdata_next = {11'h000, periph_en_reg};
            XPD_SYSCFG_OFFSET: rdata_next = syscfg_reg;
            XPD_STATUS_OFFSET: rdata_next = {11'h000, state_reg, tgt_reg};
            default: rdata_next = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         periph_en_reg <= XPD_PERIPH_ENABLE_RESET[4:0]; // [R15]
         syscfg_reg <= XPD_SYSCFG_RESET;
         rdata_reg <= 16'h0000;
      end else begin
         periph_en_reg <= periph_en_next;
         syscfg_reg <= syscfg_next;
         rdata_reg <= rdata_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Access sequencing.
   xpd_target_t dec_target;
   logic [23:0] addr_reg;
   logic [23:0] addr_next;
   logic write_reg;
   logic write_next;
   logic byte_reg;
   logic byte_next;
   logic done_reg;
   logic done_next;
   logic err_reg;
   logic err_next;
   logic timer_start;
   logic timer_done;
   logic [1:0] timer_waits;

   xpd_window_decode u_decode (
      .addr(cpu_addr),
      .global_en(syscfg_reg[XPD_GLOBAL_BIT]),
      .periph_en(periph_en_reg),
      .target(dec_target)
   );

   function automatic logic is_internal(input xpd_target_t t);
      is_internal = (t != XPD_TGT_EXT);
   endfunction : is_internal

   function automatic logic is_can(input xpd_target_t t);
      is_can = (t == XPD_TGT_CAN_A) || (t == XPD_TGT_CAN_B);
   endfunction : is_can

   always_comb begin
      state_next = state_reg;
      tgt_next = tgt_reg;
      addr_next = addr_reg;
      write_next = write_reg;
      byte_next = byte_reg;
      done_next = 1'b0;
      err_next = 1'b0;
      timer_start = 1'b0;
      timer_waits = 2'h0;
      case (state_reg)
         XPD_ST_IDLE: begin
            if (cpu_req) begin
               addr_next = cpu_addr; // [R1] [R18]
               write_next = cpu_write;
               byte_next = cpu_byte; // [R6] [R10]
               tgt_next = dec_target;
               if (cpu_bit_op && is_internal(dec_target)) begin
                  // Bit operations are refused on the extension windows.
                  done_next = 1'b1; // [R7]
                  err_next = 1'b1;
                  tgt_next = XPD_TGT_EXT;
               end else if (is_can(dec_target)) begin
                  timer_start = 1'b1;
                  timer_waits = XPD_CAN_WAIT_CYCLES; // [R10]
                  state_next = XPD_ST_WAIT;
               end else if (is_internal(dec_target)) begin
                  done_next = 1'b1; // [R6]
                  state_next = XPD_ST_DONE;
               end else begin
                  // External accesses are timed by the external bus controller.
                  done_next = 1'b1;
                  state_next = XPD_ST_DONE;
               end
            end
         end
         XPD_ST_WAIT: begin
            if (timer_done) begin
               done_next = 1'b1;
               state_next = XPD_ST_DONE;
            end
         end
         XPD_ST_DONE: begin
            // One turnaround cycle before the next request is taken.
            state_next = XPD_ST_IDLE;
            tgt_next = XPD_TGT_EXT;
         end
         default: state_next = XPD_ST_IDLE;
      endcase
   end

   // The timer ends a CAN access two cycles after a zero-wait access would end.
   // Its done pulse comes one cycle before acc_done, which the WAIT state registers.
   xpd_wait_timer u_timer (
      .clk(clk),
      .rst(rst),
      .start(timer_start),
      .waits(timer_waits),
      .done(timer_done)
   );

   always_ff @(posedge clk) begin
      if (rst) begin
         state_reg <= XPD_ST_IDLE;
         tgt_reg <= XPD_TGT_EXT;
         addr_reg <= 24'h000000;
         write_reg <= 1'b0;
         byte_reg <= 1'b0;
         done_reg <= 1'b0;
         err_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         tgt_reg <= tgt_next;
         addr_reg <= addr_next;
         write_reg <= write_next;
         byte_reg <= byte_next;
         done_reg <= done_next;
         err_reg <= err_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Pin, interrupt and segment ownership, registered.
   logic [7:0] own_reg;
   logic [7:0] own_next;
   logic ge;

   // Ownership follows the registered enables one cycle later; a peripheral left off
   // when the global enable comes up claims no pins or interrupts until the global enable is cleared.
   always_comb begin
      ge = syscfg_reg[XPD_GLOBAL_BIT];
      own_next[0] = ge && periph_en_reg[XPD_CAN_A_BIT]; // [R11] [R13]
      own_next[1] = ge && periph_en_reg[XPD_CAN_B_BIT]; // [R13]
      own_next[2] = own_next[0];
      own_next[3] = own_next[1];
      own_next[4] = periph_en_reg[XPD_RTC_BIT];
      own_next[5] = ge;
      own_next[6] = own_next[0] || own_next[1]; // [R14]
      own_next[7] = 1'b0;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         own_reg <= 8'h00;
      end else begin
         own_reg <= own_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Target selects and segment count, registered from the next values so that they
   // line up with the access state and no output pin carries decoding.
   logic [4:0] sel_reg;
   logic [4:0] sel_next;
   logic [3:0] seg_reg;
   logic [3:0] seg_next;

   // Select vector ordered external, RAM A, RAM B, CAN A, CAN B.
   function automatic logic [4:0] sel_vec(input xpd_target_t t, input xpd_state_t s);
      sel_vec = 5'h00;
      case (t)
         XPD_TGT_EXT: sel_vec[4] = (s != XPD_ST_IDLE);
         XPD_TGT_RAM_A: sel_vec[3] = 1'b1;
         XPD_TGT_RAM_B: sel_vec[2] = 1'b1;
         XPD_TGT_CAN_A: sel_vec[1] = 1'b1;
         XPD_TGT_CAN_B: sel_vec[0] = 1'b1;
         default: sel_vec = 5'h00;
      endcase
   endfunction : sel_vec

   always_comb begin
      sel_next = sel_vec(tgt_next, state_next); // [R2] [R4] [R8] [R9]
      seg_next = own_next[6] ? XPD_SEG_LINES_CAN : XPD_SEG_LINES_FULL; // [R14]
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         sel_reg <= 5'h00;
         seg_reg <= XPD_SEG_LINES_FULL;
      end else begin
         sel_reg <= sel_next;
         seg_reg <= seg_next;
      end
   end

   assign reg_rdata = rdata_reg;
   assign tgt_addr = addr_reg;
   assign tgt_write = write_reg;
   assign tgt_byte = byte_reg;
   assign sel_ext = sel_reg[4];
   assign sel_ram_a = sel_reg[3];
   assign sel_ram_b = sel_reg[2];
   assign sel_can_a = sel_reg[1];
   assign sel_can_b = sel_reg[0];
   assign acc_done = done_reg;
   assign acc_error = err_reg;
   assign can_a_pins_claimed = own_reg[0];
   assign can_b_pins_claimed = own_reg[1];
   assign can_a_irq_en = own_reg[2];
   assign can_b_irq_en = own_reg[3];
   assign rtc_en = own_reg[4];
   assign global_en = own_reg[5];
   assign seg_lines = seg_reg; // [R14]
endmodule : xpd_decoder

// *** logic/xpd_pkg.sv ***
// Package for the extension bus address decoder: register map, bit fields, windows, timing.
// Assumes a 24-bit byte address from the CPU bus master and a 10 MHz system clock.
package xpd_pkg;
   localparam logic [15:0] XPD_PERIPH_ENABLE_OFFSET = 16'hf024;
   localparam logic [15:0] XPD_SYSCFG_OFFSET = 16'hf026;
   localparam logic [15:0] XPD_STATUS_OFFSET = 16'hf028;
   localparam logic [15:0] XPD_PERIPH_ENABLE_RESET = 16'h0005;
   localparam logic [15:0] XPD_SYSCFG_RESET = 16'h0000;
   localparam int XPD_CAN_A_BIT = 0;
   localparam int XPD_CAN_B_BIT = 1;
   localparam int XPD_RAM_A_BIT = 2;
   localparam int XPD_RAM_B_BIT = 3;
   localparam int XPD_RTC_BIT = 4;
   localparam int XPD_GLOBAL_BIT = 2;
   localparam logic [4:0] XPD_PERIPH_ENABLE_MASK = 5'h1f;
   localparam logic [23:0] XPD_RAM_A_LO = 24'h00e000;
   localparam logic [23:0] XPD_RAM_A_HI = 24'h00e7ff;
   localparam logic [23:0] XPD_RAM_B_LO = 24'h00c000;
   localparam logic [23:0] XPD_RAM_B_HI = 24'h00dfff;
   localparam logic [23:0] XPD_CAN_A_LO = 24'h00ef00;
   localparam logic [23:0] XPD_CAN_A_HI = 24'h00efff;
   localparam logic [23:0] XPD_CAN_B_LO = 24'h00ee00;
   localparam logic [23:0] XPD_CAN_B_HI = 24'h00eeff;
   localparam int XPD_RAM_ACCESS_NS = 62;
   localparam int XPD_CAN_WAIT_STATES = 2;
   localparam int XPD_CLK_PERIOD_NS = 100;
   localparam logic [1:0] XPD_CAN_WAIT_CYCLES = 2'(XPD_CAN_WAIT_STATES);
   localparam logic [3:0] XPD_SEG_LINES_FULL = 4'h8;
   localparam logic [3:0] XPD_SEG_LINES_CAN = 4'h4;
   typedef enum logic [2:0] {
      XPD_TGT_EXT = 3'b000,
      XPD_TGT_RAM_A = 3'b001,
      XPD_TGT_RAM_B = 3'b010,
      XPD_TGT_CAN_A = 3'b011,
      XPD_TGT_CAN_B = 3'b100
   } xpd_target_t;
   typedef enum logic [1:0] {
      XPD_ST_IDLE = 2'b00,
      XPD_ST_WAIT = 2'b01,
      XPD_ST_DONE = 2'b10
   } xpd_state_t;
endpackage : xpd_pkg

// *** logic/xpd_window_decode.sv ***
// Combinational window decoder: maps a 24-bit address and enables to a target.
// Assumes the enables are registered by the caller.
`timescale 1ns/1ps
module xpd_window_decode
   import xpd_pkg::*;
(
   input wire logic [23:0] addr,
   input wire logic global_en,
   input wire logic [4:0] periph_en,
   output xpd_target_t target
);
   function automatic logic in_win(input logic [23:0] a, input logic [23:0] lo,
                                   input logic [23:0] hi);
      in_win = (a >= lo) && (a <= hi);
   endfunction : in_win

   always_comb begin
      target = XPD_TGT_EXT; // [R18]
      if (global_en && periph_en[XPD_RAM_A_BIT] && in_win(addr, XPD_RAM_A_LO, XPD_RAM_A_HI)) begin
         target = XPD_TGT_RAM_A; // [R2] [R3]
      end else if (global_en && periph_en[XPD_RAM_B_BIT]
                   && in_win(addr, XPD_RAM_B_LO, XPD_RAM_B_HI)) begin
         target = XPD_TGT_RAM_B; // [R4] [R5]
      end else if (global_en && periph_en[XPD_CAN_A_BIT]
                   && in_win(addr, XPD_CAN_A_LO, XPD_CAN_A_HI)) begin
         target = XPD_TGT_CAN_A; // [R8]
      end else if (global_en && periph_en[XPD_CAN_B_BIT]
                   && in_win(addr, XPD_CAN_B_LO, XPD_CAN_B_HI)) begin
         target = XPD_TGT_CAN_B; // [R9]
      end else if (global_en && periph_en[XPD_CAN_B_BIT]
                   && in_win(addr, XPD_CAN_A_LO, XPD_CAN_A_HI)) begin
         // With module A off but module B on, A's window stays internal and is routed to CAN B.
         target = XPD_TGT_CAN_B; // [R12]
      end
      // Both modules off: the whole CAN span falls through to external. [R17]
   end
endmodule : xpd_window_decode

// *** logic/xpd_wait_timer.sv ***
// Wait state counter: pulses done in time for its caller to end the access after the waits.
// Assumes start is a one-cycle pulse, waits is at least one, and no start comes before done.
`timescale 1ns/1ps
module xpd_wait_timer
   import xpd_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic start,
   input wire logic [1:0] waits,
   output logic done
);
   logic [1:0] cnt_reg;
   logic [1:0] cnt_next;
   logic busy_reg;
   logic busy_next;
   logic done_reg;
   logic done_next;

   always_comb begin
      cnt_next = cnt_reg;
      busy_next = busy_reg;
      done_next = 1'b0;
      if (start) begin
         // The done pulse is registered here and again by the caller, so the countdown
         // starts one short to keep the access at exactly the wait count.
         if (waits <= 2'h1) begin
            done_next = 1'b1;
         end else begin
            cnt_next = waits - 2'h1;
            busy_next = 1'b1;
         end
      end else if (busy_reg) begin
         cnt_next = cnt_reg - 2'h1;
         if (cnt_reg == 2'h1) begin
            busy_next = 1'b0;
            done_next = 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_reg <= 2'h0;
         busy_reg <= 1'b0;
         done_reg <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         busy_reg <= busy_next;
         done_reg <= done_next;
      end
   end

   assign done = done_reg;
endmodule : xpd_wait_timer

// *** tb/xpd_cpu_model.sv ***
// CPU bus master model: one access per start pulse, outcome recorded at acc_done.
// Assumes the decoder answers within 16 cycles and start comes only while idle.
`timescale 1ns/1ps
module xpd_cpu_model
   import xpd_pkg::*;
(
   input wire logic clk,
   input wire logic start,
   input wire logic [23:0] addr_in,
   input wire logic write_in,
   input wire logic byte_in,
   input wire logic bit_in,
   input wire logic acc_done,
   input wire logic acc_error,
   input wire logic [4:0] sel,
   output logic [23:0] cpu_addr,
   output logic cpu_req,
   output logic cpu_write,
   output logic cpu_byte,
   output logic cpu_bit_op,
   output logic busy,
   output logic [3:0] lat,
   output logic [4:0] sel_seen,
   output logic err_seen
);
   initial begin
      cpu_addr = 24'h000000;
      cpu_req = 1'b0;
      cpu_write = 1'b0;
      cpu_byte = 1'b0;
      cpu_bit_op = 1'b0;
      busy = 1'b0;
      lat = 4'h0;
   end
   // The request is a one-cycle pulse; address and flags stay put until the next start.
   always @(posedge clk) begin
      cpu_req <= 1'b0;
      if (start) begin
         cpu_req <= 1'b1;
         cpu_addr <= addr_in;
         cpu_write <= write_in;
         cpu_byte <= byte_in;
         cpu_bit_op <= bit_in;
         busy <= 1'b1;
         lat <= 4'h0;
      end else if (busy) begin
         if (acc_done) begin
            busy <= 1'b0;
            sel_seen <= sel;
            err_seen <= acc_error;
         end else begin
            lat <= lat + 4'h1;
         end
      end
   end
endmodule : xpd_cpu_model

// *** tb/xpd_decoder_chk.sv ***
// Checker for the extension bus decoder, bound to its top module.
// Assumes single clock clk and synchronous active-high reset rst.
`timescale 1ns/1ps
module xpd_decoder_chk (
   input wire logic clk,
   input wire logic rst,
   input wire logic [23:0] cpu_addr,
   input wire logic [23:0] tgt_addr,
   input wire logic sel_ext,
   input wire logic sel_ram_a,
   input wire logic sel_ram_b,
   input wire logic sel_can_a,
   input wire logic sel_can_b,
   input wire logic acc_done,
   input wire logic acc_error,
   input wire logic can_a_pins_claimed,
   input wire logic can_b_pins_claimed,
   input wire logic [3:0] seg_lines,
   input wire logic global_en
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   sequence can_wait_s;
      !acc_done [*2] ##1 acc_done;
   endsequence
   ram_zero_wait_a: assert property ($rose(sel_ram_a) || $rose(sel_ram_b) |-> acc_done)
      else $error("RAM access not done at once");
   can_a_wait_a: assert property ($rose(sel_can_a) |-> can_wait_s)
      else $error("CAN A wait count wrong");
   can_b_wait_a: assert property ($rose(sel_can_b) |-> can_wait_s)
      else $error("CAN B wait count wrong");
   ram_gate_a: assert property (sel_ram_a || sel_ram_b |-> global_en)
      else $error("RAM selected while bus disabled");
   can_a_owner_a: assert property (sel_can_a |-> can_a_pins_claimed && global_en)
      else $error("CAN A selected while disabled");
   can_b_owner_a: assert property (sel_can_b |-> can_b_pins_claimed)
      else $error("CAN B selected while disabled");
   seg_count_a: assert property (
      seg_lines == ((can_a_pins_claimed || can_b_pins_claimed) ? 4'h4 : 4'h8))
      else $error("segment line count wrong");
   one_target_a: assert property (
      $onehot0({sel_ext, sel_ram_a, sel_ram_b, sel_can_a, sel_can_b}))
      else $error("more than one target selected");
   ext_addr_a: assert property ($rose(sel_ext) |-> tgt_addr == $past(cpu_addr))
      else $error("external address altered");
   bit_refuse_a: assert property (acc_error |-> acc_done && !(sel_ram_a || sel_ram_b))
      else $error("bit access not refused cleanly");
   enable_frozen_a: assert property (
      global_en && $past(global_en) && $past(global_en, 2)
      |-> $stable(can_a_pins_claimed) && $stable(can_b_pins_claimed))
      else $error("enables changed after global enable");
endmodule : xpd_decoder_chk
bind xpd_decoder xpd_decoder_chk i_chk (.clk(clk), .rst(rst), .cpu_addr(cpu_addr),
   .tgt_addr(tgt_addr), .sel_ext(sel_ext), .sel_ram_a(sel_ram_a), .sel_ram_b(sel_ram_b),
   .sel_can_a(sel_can_a), .sel_can_b(sel_can_b), .acc_done(acc_done), .acc_error(acc_error),
   .can_a_pins_claimed(can_a_pins_claimed), .can_b_pins_claimed(can_b_pins_claimed),
   .seg_lines(seg_lines), .global_en(global_en));

// *** tb/xpd_decoder_test.sv ***
// Testbench for the extension bus decoder: a table of routed accesses, then hand tests.
// Assumes the CPU model xpd_cpu_model and the bound checker.
`timescale 1ns/1ps
module xpd_decoder_test import xpd_pkg::*;;
   typedef struct packed {logic [4:0] en; logic g; logic bt; logic [23:0] a;
      logic [4:0] sel; logic [3:0] lat; logic err;} xpd_row_t;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [15:0] reg_addr = 16'h0000;
   logic [15:0] reg_wdata = 16'h0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic start = 1'b0;
   logic [23:0] a_in = 24'h000000;
   logic w_in = 1'b0;
   logic b_in = 1'b0;
   logic bit_in = 1'b0;
   logic [15:0] reg_rdata;
   logic [23:0] cpu_addr, tgt_addr;
   logic cpu_req, cpu_write, cpu_byte, cpu_bit_op, tgt_write, tgt_byte, acc_done, acc_error;
   logic sel_ext, sel_ram_a, sel_ram_b, sel_can_a, sel_can_b, rtc_en, global_en, busy, err_seen;
   logic can_a_pins_claimed, can_b_pins_claimed, can_a_irq_en, can_b_irq_en;
   logic [3:0] seg_lines, lat;
   logic [4:0] sel_seen;
   int bad_count = 0;
   int n_compared = 0;
   // Columns: enables, global, bit op, address, selects {ext,ram a,ram b,can a,can b}, latency, error.
   xpd_row_t rows [12] = '{
      '{5'h05, 1'b1, 1'b0, 24'h00e010, 5'b01000, 4'h1, 1'b0},
      '{5'h05, 1'b0, 1'b0, 24'h00e7ff, 5'b10000, 4'h1, 1'b0},
      '{5'h01, 1'b1, 1'b0, 24'h00e000, 5'b10000, 4'h1, 1'b0},
      '{5'h08, 1'b1, 1'b0, 24'h00c000, 5'b00100, 4'h1, 1'b0},
      '{5'h00, 1'b1, 1'b0, 24'h00dfff, 5'b10000, 4'h1, 1'b0},
      '{5'h01, 1'b1, 1'b0, 24'h00efff, 5'b00010, 4'h3, 1'b0},
      '{5'h02, 1'b1, 1'b0, 24'h00ee00, 5'b00001, 4'h3, 1'b0},
      '{5'h02, 1'b1, 1'b0, 24'h00ef10, 5'b00001, 4'h3, 1'b0},
      '{5'h00, 1'b1, 1'b0, 24'h00ef00, 5'b10000, 4'h1, 1'b0},
      '{5'h01, 1'b1, 1'b0, 24'h00eeff, 5'b10000, 4'h1, 1'b0},
      '{5'h05, 1'b1, 1'b0, 24'hfedcba, 5'b10000, 4'h1, 1'b0},
      '{5'h05, 1'b1, 1'b1, 24'h00e010, 5'b00000, 4'h1, 1'b1}};
   xpd_decoder i_dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cpu_addr(cpu_addr),
      .cpu_req(cpu_req), .cpu_write(cpu_write), .cpu_byte(cpu_byte), .cpu_bit_op(cpu_bit_op),
      .tgt_addr(tgt_addr), .tgt_write(tgt_write), .tgt_byte(tgt_byte), .sel_ext(sel_ext),
      .sel_ram_a(sel_ram_a), .sel_ram_b(sel_ram_b), .sel_can_a(sel_can_a),
      .sel_can_b(sel_can_b), .acc_done(acc_done), .acc_error(acc_error),
      .can_a_pins_claimed(can_a_pins_claimed), .can_b_pins_claimed(can_b_pins_claimed),
      .can_a_irq_en(can_a_irq_en), .can_b_irq_en(can_b_irq_en), .rtc_en(rtc_en),
      .seg_lines(seg_lines), .global_en(global_en));
   xpd_cpu_model i_cpu (.clk(clk), .start(start), .addr_in(a_in), .write_in(w_in),
      .byte_in(b_in), .bit_in(bit_in), .acc_done(acc_done), .acc_error(acc_error),
      .sel({sel_ext, sel_ram_a, sel_ram_b, sel_can_a, sel_can_b}), .cpu_addr(cpu_addr),
      .cpu_req(cpu_req), .cpu_write(cpu_write), .cpu_byte(cpu_byte), .cpu_bit_op(cpu_bit_op),
      .busy(busy), .lat(lat), .sel_seen(sel_seen), .err_seen(err_seen));
   initial forever #50 clk = ~clk;
   ////////////////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [15:0] ad, input logic [15:0] d);
      @(posedge clk);
      reg_addr <= ad;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [15:0] ad, input logic [15:0] exp);
      @(posedge clk);
      reg_addr <= ad;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 chk(24'(reg_rdata), 24'(exp));
   endtask : rd
   task automatic acc(input xpd_row_t r, input logic w, input logic b);
      logic ca;
      logic cb;
      logic [3:0] own;
      ca = r.g & r.en[0];
      cb = r.g & r.en[1];
      wr(XPD_SYSCFG_OFFSET, 16'h0000);
      wr(XPD_PERIPH_ENABLE_OFFSET, {11'h000, r.en});
      wr(XPD_SYSCFG_OFFSET, r.g ? 16'h0004 : 16'h0000);
      @(posedge clk);
      a_in <= r.a;
      w_in <= w;
      b_in <= b;
      bit_in <= r.bt;
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      repeat (16) begin
         @(posedge clk);
         #1;
         if (!busy) break;
      end
      own = {can_a_pins_claimed, can_b_pins_claimed, can_a_irq_en, can_b_irq_en};
      chk(24'(sel_seen), 24'(r.sel));
      chk(24'({busy, err_seen, lat}), 24'({1'b0, r.err, r.lat}));
      chk(24'(own), 24'({ca, cb, ca, cb}));
      chk(24'(seg_lines), (ca | cb) ? 24'h000004 : 24'h000008);
      chk(tgt_addr, r.a);
      chk(24'({tgt_write, tgt_byte}), 24'({w, b}));
   endtask : acc
   task automatic results();
      $display("Compared %0d, mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : results
   ////////////////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      #1 chk(24'({global_en, can_a_pins_claimed, seg_lines}), 24'h000008);
      rd(XPD_PERIPH_ENABLE_OFFSET, 16'h0005);
      rd(16'h0000, 16'h0000);
      foreach (rows[i]) acc(rows[i], i[0], i[1]);
      wr(XPD_SYSCFG_OFFSET, 16'h0000);
      wr(XPD_PERIPH_ENABLE_OFFSET, 16'hffff);
      rd(XPD_PERIPH_ENABLE_OFFSET, 16'h001f);
      wr(XPD_SYSCFG_OFFSET, 16'h0004);
      wr(XPD_PERIPH_ENABLE_OFFSET, 16'h0000);
      rd(XPD_PERIPH_ENABLE_OFFSET, 16'h001f);
      rd(XPD_SYSCFG_OFFSET, 16'h0004);
      rd(XPD_STATUS_OFFSET, 16'h0000);
      chk(24'(rtc_en), 24'h000001);
      // A second reset in mid-run must bring the enables back to their defaults.
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      rd(XPD_PERIPH_ENABLE_OFFSET, 16'h0005);
      chk(24'({global_en, rtc_en, seg_lines}), 24'h000008);
      results();
   end
   initial begin
      repeat (4000) @(posedge clk);
      bad_count++;
      results();
   end
endmodule : xpd_decoder_test
